// ---- logic/cprhst_pkg.sv ----
/*
  constants for the content-protection host sequencer: register map of
  both link ends, copy layout, counts and the sequencer state type.
  assumes byte-wide register access to serializer and deserializer.
*/
package cprhst_pkg;

  // target select on the register port
  localparam logic DEV_SER = 1'b0;
  localparam logic DEV_DES = 1'b1;

  // serializer register map
  localparam logic [7:0] SER_CTRL = 8'h80; // start, restart, cipher on
  localparam logic [7:0] SER_AN = 8'h90; // session random, 8 bytes
  localparam logic [7:0] SER_TXKEY = 8'h98; // transmitter key, 5 bytes
  localparam logic [7:0] SER_RXKEY = 8'ha0; // receiver key copy, 5 bytes
  localparam logic [7:0] SER_RESP = 8'ha8; // own response, 2 bytes
  localparam logic [7:0] SER_RESP_IN = 8'haa; // far response in, 2 bytes
  localparam logic [7:0] SER_ECV = 8'hac; // own enhanced check value
  localparam logic [7:0] SER_STAT = 8'had; // response_match_flag

  // deserializer register map
  localparam logic [7:0] DES_CTRL = 8'h80; // cipher on, repeater
  localparam logic [7:0] DES_AN = 8'h90;
  localparam logic [7:0] DES_TXKEY = 8'h98;
  localparam logic [7:0] DES_RXKEY = 8'ha0;
  localparam logic [7:0] DES_RESP = 8'ha8; // initial_response, 2 bytes
  localparam logic [7:0] DES_ECV = 8'hac; // enhanced_check_value

  // control and status bit positions
  localparam int CTL_START = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_ENC = 2;
  localparam int CTL_INTCMP = 3;
  localparam int CTL_REPEATER = 4;
  localparam int STAT_MATCH = 0;

  // copy layout: random value, transmitter key, receiver key
  localparam logic [4:0] CP_AN_END = 5'd8;
  localparam logic [4:0] CP_TX_END = 5'd13;
  localparam logic [4:0] CP_LAST = 5'd17;

  // key and topology limits
  localparam logic [5:0] KEY_ONES = 6'd20;
  localparam logic [4:0] MAX_RX = 5'd15;
  localparam logic [1:0] ECV_MISS_LIMIT = 2'd3;
  localparam logic [3:0] ECV_FRAME_LAST = 4'hf; // every 16 frames
  localparam logic [6:0] RESP_FRAME_LAST = 7'h7f; // every 128 frames

  // response wait: 128 pixel clocks at the slowest pixel rate
  localparam int MCLK_KHZ = 20000;
  localparam int PCLK_MIN_KHZ = 5000;
  localparam int RESP_PCLK = 128;
  localparam int RESP_WAIT_CYC =
    (RESP_PCLK * MCLK_KHZ + PCLK_MIN_KHZ - 1) / PCLK_MIN_KHZ;
  localparam logic [9:0] RESP_WAIT_LAST = 10'(RESP_WAIT_CYC - 1);

  // integrity timer fallback, 2 s
  localparam int CHK_PERIOD_S = 2;
  localparam int CHK_PERIOD_CYC = CHK_PERIOD_S * MCLK_KHZ * 1000;

  // sequencer states, gray along the authentication path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RESTART = 4'h1,
    ST_START = 4'h3,
    ST_REPEAT = 4'h2,
    ST_CP_RD = 4'h6,
    ST_CP_WR = 4'h7,
    ST_RWAIT = 4'h5,
    ST_RESP = 4'h4,
    ST_JUDGE = 4'hc,
    ST_RUN = 4'hd,
    ST_ENC_WAIT = 4'hf,
    ST_ENC_WR = 4'he,
    ST_FAIL = 4'ha
  } cprhst_state_t;

endpackage

// ---- logic/cprhst_mem.sv ----
/*
  small byte store for the key material moved between link ends.
  registered read with write-through, single clock, no reset on data.
*/
`timescale 1ns/1ps
`default_nettype none

module cprhst_mem
(
  // clock
  input wire logic mclk,
  // write side
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  // read side
  input wire logic [4:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem_q [0:31]; // key bytes

  // write-through so a byte just fetched can be forwarded next cycle
  always_ff @(posedge mclk)
  begin
    if (we)
      mem_q[waddr] <= wdata;
    if (we && waddr == raddr)
      rdata <= wdata;
    else
      rdata <= mem_q[raddr];
  end

endmodule

`default_nettype wire

// ---- logic/cprhst_ctrl.sv ----
/*
  host-side sequencer for link content protection: authenticates,
  checks link integrity, and switches the cipher in step with vsync.
  assumes a byte register port that reaches both link ends, and vsync
  taken synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - copy random, transmitter key, receiver key
// - comparison mode bit: internal or host
// - internal mode, full checks only: forward response, read match
// - check receiver key ones count, revocation
// - mismatch: resample once, then restart
// - integrity check every 128 frames or 2s
// - resample only after three check mismatches
// - cipher bit both ends, same vsync cycle
// - authenticate before cipher on, off before new
// - repeater bit set when in repeater
// - no more than 15 receivers in total
// - revoked key: withhold protected content
module cprhst_ctrl
#(
  parameter int CHK_PERIOD_CYC = cprhst_pkg::CHK_PERIOD_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // user orders
  input wire logic start_auth,
  input wire logic int_comp_sel,
  input wire logic repeater_sel,
  input wire logic key_revoked,
  input wire logic [4:0] rx_total,
  input wire logic enc_request,
  input wire logic enh_check_en,
  // user status
  output logic busy,
  output logic authenticated,
  output logic auth_failed,
  output logic receiver_key_invalid_flag,
  output logic enc_active,
  output logic content_allow,
  output logic [15:0] last_response,
  // register port to both link ends
  output logic reg_req,
  output logic reg_wr,
  output logic reg_dev,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  // video timing
  input wire logic vsync
);

  // bit count of one byte
  function automatic logic [3:0] ones8(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
      n = n + {3'b000, b[i]};
    return n;
  endfunction

  cprhst_pkg::cprhst_state_t st_q; // sequencer state
  logic [4:0] cnt_q; // copy byte index
  logic [2:0] idx_q; // response op index
  logic [9:0] wait_q; // response wait count
  logic [5:0] ones_q; // ones in receiver key
  logic [15:0] rx_q; // device response
  logic [15:0] tx_q; // serializer response
  logic match_q; // internal match flag seen
  logic chk_q; // 1: enhanced check, 0: full response
  logic first_q; // judging initial authentication
  logic retry_q; // one resample spent
  logic [1:0] miss_q; // consecutive enhanced misses
  logic enc_q; // cipher on at both ends
  logic enc_val_q; // value being written
  logic sub_q; // 0 serializer, 1 deserializer write
  logic go_q; // continue to start after restart
  logic auth_q; // link authenticated
  logic fail_q; // authentication failed
  logic intc_q; // comparison mode latched
  logic vs_q; // vsync last cycle
  logic [6:0] frm_q; // frames since check
  logic [25:0] tmr_q; // integrity fallback timer
  logic req_q; // request outstanding
  logic wr_q;
  logic dev_q;
  logic [7:0] addr_q;
  logic [7:0] wd_q;

  // bus decode
  logic done_w;
  logic bus_st_w;
  logic [7:0] mem_rd_w;
  logic cp_src_w;
  logic [7:0] cp_src_a_w;
  logic [7:0] cp_dst_a_w;
  logic [1:0] nb_w;
  logic [2:0] rel_w;
  logic int_eff_w;
  logic resp_last_w;
  logic op_wr_w;
  logic op_dev_w;
  logic [7:0] op_addr_w;
  logic [7:0] op_wd_w;
  logic bus_wr_w;
  logic bus_dev_w;
  logic [7:0] bus_addr_w;
  logic [7:0] bus_wd_w;
  logic [7:0] ser_ctl_w;
  logic [7:0] des_ctl_w;
  logic vs_fall_w;
  logic resp_due_w;
  logic ecv_due_w;
  logic match_w;
  logic reject_w;

  assign done_w = req_q & reg_ack;
  assign bus_st_w = (st_q == cprhst_pkg::ST_RESTART) |
                    (st_q == cprhst_pkg::ST_START) |
                    (st_q == cprhst_pkg::ST_REPEAT) |
                    (st_q == cprhst_pkg::ST_CP_RD) |
                    (st_q == cprhst_pkg::ST_CP_WR) |
                    (st_q == cprhst_pkg::ST_RESP) |
                    (st_q == cprhst_pkg::ST_ENC_WR);

  // copy order: random and transmitter key go to device, its key back
  assign cp_src_w = (cnt_q >= cprhst_pkg::CP_TX_END) ?
                    cprhst_pkg::DEV_DES : cprhst_pkg::DEV_SER;
  assign cp_src_a_w =
    (cnt_q < cprhst_pkg::CP_AN_END) ? cprhst_pkg::SER_AN + {3'b000, cnt_q} :
    (cnt_q < cprhst_pkg::CP_TX_END) ?
      cprhst_pkg::SER_TXKEY + {3'b000, cnt_q - cprhst_pkg::CP_AN_END} :
      cprhst_pkg::DES_RXKEY + {3'b000, cnt_q - cprhst_pkg::CP_TX_END};
  assign cp_dst_a_w =
    (cnt_q < cprhst_pkg::CP_AN_END) ? cprhst_pkg::DES_AN + {3'b000, cnt_q} :
    (cnt_q < cprhst_pkg::CP_TX_END) ?
      cprhst_pkg::DES_TXKEY + {3'b000, cnt_q - cprhst_pkg::CP_AN_END} :
      cprhst_pkg::SER_RXKEY + {3'b000, cnt_q - cprhst_pkg::CP_TX_END};

  // response ops: device bytes, then serializer bytes or forward
  assign nb_w = chk_q ? 2'd1 : 2'd2;
  assign rel_w = idx_q - {1'b0, nb_w};
  assign int_eff_w = intc_q & ~chk_q;
  assign resp_last_w = int_eff_w ? (idx_q == {nb_w, 1'b0}) :
                       (idx_q == {nb_w, 1'b0} - 3'd1);
  assign op_wr_w = int_eff_w & (idx_q >= {1'b0, nb_w}) &
                   (idx_q < {nb_w, 1'b0});
  assign op_dev_w = (idx_q < {1'b0, nb_w}) ? cprhst_pkg::DEV_DES :
                    cprhst_pkg::DEV_SER;
  assign op_addr_w =
    (idx_q < {1'b0, nb_w}) ?
      (chk_q ? cprhst_pkg::DES_ECV : cprhst_pkg::DES_RESP + {5'h00, idx_q}) :
    (idx_q == {nb_w, 1'b0}) ? cprhst_pkg::SER_STAT :
    op_wr_w ? cprhst_pkg::SER_RESP_IN + {5'h00, rel_w} :
    (chk_q ? cprhst_pkg::SER_ECV : cprhst_pkg::SER_RESP + {5'h00, rel_w});
  assign op_wd_w = rel_w[0] ? rx_q[15:8] : rx_q[7:0];

  // control bytes; cipher bit goes out with every control write
  assign ser_ctl_w = 8'h00 |
    ({7'h00, (st_q == cprhst_pkg::ST_START)} << cprhst_pkg::CTL_START) |
    ({7'h00, (st_q == cprhst_pkg::ST_RESTART)} << cprhst_pkg::CTL_RESTART) |
    ({7'h00, enc_val_q} << cprhst_pkg::CTL_ENC) |
    ({7'h00, intc_q} << cprhst_pkg::CTL_INTCMP);
  assign des_ctl_w = 8'h00 |
    ({7'h00, enc_val_q} << cprhst_pkg::CTL_ENC) |
    ({7'h00, repeater_sel} << cprhst_pkg::CTL_REPEATER);

  // field select per state
  assign bus_wr_w = (st_q != cprhst_pkg::ST_CP_RD) &
                    ((st_q != cprhst_pkg::ST_RESP) | op_wr_w);
  assign bus_dev_w =
    (st_q == cprhst_pkg::ST_CP_RD) ? cp_src_w :
    (st_q == cprhst_pkg::ST_CP_WR) ? ~cp_src_w :
    (st_q == cprhst_pkg::ST_RESP) ? op_dev_w :
    (st_q == cprhst_pkg::ST_REPEAT) ? cprhst_pkg::DEV_DES :
    (st_q == cprhst_pkg::ST_ENC_WR) ? sub_q : cprhst_pkg::DEV_SER;
  assign bus_addr_w =
    (st_q == cprhst_pkg::ST_CP_RD) ? cp_src_a_w :
    (st_q == cprhst_pkg::ST_CP_WR) ? cp_dst_a_w :
    (st_q == cprhst_pkg::ST_RESP) ? op_addr_w :
    (bus_dev_w == cprhst_pkg::DEV_DES) ? cprhst_pkg::DES_CTRL :
    cprhst_pkg::SER_CTRL;
  assign bus_wd_w =
    (st_q == cprhst_pkg::ST_CP_WR) ? mem_rd_w :
    (st_q == cprhst_pkg::ST_RESP) ? op_wd_w :
    (bus_dev_w == cprhst_pkg::DEV_DES) ? des_ctl_w : ser_ctl_w;

  // frame events and checks due
  assign vs_fall_w = vs_q & ~vsync;
  assign resp_due_w = (vs_fall_w & (frm_q == cprhst_pkg::RESP_FRAME_LAST)) |
                      (tmr_q == 26'(CHK_PERIOD_CYC - 1));
  assign ecv_due_w = enh_check_en & vs_fall_w &
                     (frm_q[3:0] == cprhst_pkg::ECV_FRAME_LAST);

  // verdict of the last comparison
  assign match_w = int_eff_w ? match_q :
                   chk_q ? (rx_q[7:0] == tx_q[7:0]) : (rx_q == tx_q);
  assign reject_w = (ones_q != cprhst_pkg::KEY_ONES) | key_revoked |
                    (rx_total > cprhst_pkg::MAX_RX);

  // key bytes in flight
  cprhst_mem u_mem
  (
    .mclk(mclk),
    .we(st_q == cprhst_pkg::ST_CP_RD && done_w),
    .waddr(cnt_q),
    .wdata(reg_rdata),
    .raddr(cnt_q),
    .rdata(mem_rd_w)
  );

  // request fields registered, held while a request is open
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_q <= 1'b0;
      wr_q <= 1'b0;
      dev_q <= 1'b0;
      addr_q <= 8'h00;
      wd_q <= 8'h00;
    end
    else
    begin
      req_q <= bus_st_w & ~done_w;
      wr_q <= bus_wr_w;
      dev_q <= bus_dev_w;
      addr_q <= bus_addr_w;
      wd_q <= bus_wd_w;
    end
  end

  // frame counter and fallback timer, only while the cipher runs
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vs_q <= 1'b0;
      frm_q <= 7'h00;
      tmr_q <= 26'h0000000;
    end
    else
    begin
      vs_q <= vsync;
      if (!enc_q || (st_q == cprhst_pkg::ST_RUN && resp_due_w))
      begin
        frm_q <= 7'h00;
        tmr_q <= 26'h0000000;
      end
      else
      begin
        if (vs_fall_w)
          frm_q <= frm_q + 7'h01;
        if (tmr_q != 26'(CHK_PERIOD_CYC - 1))
          tmr_q <= tmr_q + 26'h0000001;
      end
    end
  end

  // data captured from reads
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      match_q <= 1'b0;
      ones_q <= 6'h00;
    end
    else if (st_q == cprhst_pkg::ST_START)
      ones_q <= 6'h00;
    else if (done_w && st_q == cprhst_pkg::ST_CP_RD &&
             cnt_q >= cprhst_pkg::CP_TX_END)
      ones_q <= ones_q + {2'b00, ones8(reg_rdata)};
    else if (done_w && st_q == cprhst_pkg::ST_RESP && !op_wr_w)
    begin
      if (idx_q == 3'd0)
        rx_q[7:0] <= reg_rdata;
      else if (idx_q == 3'd1 && !chk_q)
        rx_q[15:8] <= reg_rdata;
      else if (idx_q == {nb_w, 1'b0})
        match_q <= reg_rdata[cprhst_pkg::STAT_MATCH];
      else if (rel_w[0])
        tx_q[15:8] <= reg_rdata;
      else
        tx_q[7:0] <= reg_rdata;
    end
  end

  // sequencer
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= cprhst_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      idx_q <= 3'h0;
      wait_q <= 10'h000;
      chk_q <= 1'b0;
      first_q <= 1'b0;
      retry_q <= 1'b0;
      miss_q <= 2'b00;
      enc_q <= 1'b0;
      enc_val_q <= 1'b0;
      sub_q <= 1'b0;
      go_q <= 1'b0;
      auth_q <= 1'b0;
      fail_q <= 1'b0;
      intc_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        cprhst_pkg::ST_IDLE, cprhst_pkg::ST_RUN:
        begin
          // new session: cipher off first, then restart
          if (start_auth)
          begin
            go_q <= 1'b1;
            auth_q <= 1'b0;
            fail_q <= 1'b0;
            intc_q <= int_comp_sel;
            enc_val_q <= 1'b0;
            st_q <= enc_q ? cprhst_pkg::ST_ENC_WAIT :
                    cprhst_pkg::ST_RESTART;
          end
          else if (st_q == cprhst_pkg::ST_RUN)
          begin
            if (enc_request != enc_q)
            begin
              enc_val_q <= enc_request;
              st_q <= cprhst_pkg::ST_ENC_WAIT;
            end
            else if (enc_q && (resp_due_w || ecv_due_w))
            begin
              chk_q <= ~resp_due_w; // full check wins
              first_q <= 1'b0;
              retry_q <= 1'b0;
              idx_q <= 3'h0;
              st_q <= cprhst_pkg::ST_RESP;
            end
          end
        end
        cprhst_pkg::ST_RESTART:
          if (done_w)
            st_q <= go_q ? cprhst_pkg::ST_START : cprhst_pkg::ST_IDLE;
        cprhst_pkg::ST_START:
          if (done_w)
            st_q <= cprhst_pkg::ST_REPEAT;
        cprhst_pkg::ST_REPEAT:
          if (done_w)
          begin
            cnt_q <= 5'h00;
            st_q <= cprhst_pkg::ST_CP_RD;
          end
        cprhst_pkg::ST_CP_RD:
          if (done_w)
            st_q <= cprhst_pkg::ST_CP_WR;
        cprhst_pkg::ST_CP_WR:
          if (done_w)
          begin
            cnt_q <= cnt_q + 5'h01;
            wait_q <= 10'h000;
            st_q <= (cnt_q == cprhst_pkg::CP_LAST) ?
                    cprhst_pkg::ST_RWAIT : cprhst_pkg::ST_CP_RD;
          end
        cprhst_pkg::ST_RWAIT:
        begin
          // device response settles within the pixel-clock bound
          wait_q <= wait_q + 10'h001;
          if (wait_q == cprhst_pkg::RESP_WAIT_LAST)
          begin
            chk_q <= 1'b0;
            first_q <= 1'b1;
            retry_q <= 1'b0;
            idx_q <= 3'h0;
            st_q <= cprhst_pkg::ST_RESP;
          end
        end
        cprhst_pkg::ST_RESP:
          if (done_w)
          begin
            idx_q <= idx_q + 3'h1;
            if (resp_last_w)
              st_q <= cprhst_pkg::ST_JUDGE;
          end
        cprhst_pkg::ST_JUDGE:
        begin
          idx_q <= 3'h0;
          if (match_w && chk_q)
          begin
            miss_q <= 2'b00;
            st_q <= cprhst_pkg::ST_RUN;
          end
          else if (chk_q)
          begin
            // single misses are noise; three in a row resample
            miss_q <= miss_q + 2'b01;
            if (miss_q + 2'b01 == cprhst_pkg::ECV_MISS_LIMIT)
            begin
              miss_q <= 2'b00;
              chk_q <= 1'b0;
              retry_q <= 1'b0;
              st_q <= cprhst_pkg::ST_RESP;
            end
            else
              st_q <= cprhst_pkg::ST_RUN;
          end
          else if (match_w)
          begin
            if (first_q && reject_w)
              st_q <= cprhst_pkg::ST_FAIL;
            else
            begin
              auth_q <= 1'b1;
              go_q <= 1'b0;
              st_q <= cprhst_pkg::ST_RUN;
            end
          end
          else if (!retry_q)
          begin
            retry_q <= 1'b1;
            st_q <= cprhst_pkg::ST_RESP;
          end
          else
            st_q <= cprhst_pkg::ST_FAIL;
        end
        cprhst_pkg::ST_FAIL:
        begin
          auth_q <= 1'b0;
          fail_q <= 1'b1;
          go_q <= 1'b0;
          enc_val_q <= 1'b0;
          st_q <= enc_q ? cprhst_pkg::ST_ENC_WAIT :
                  cprhst_pkg::ST_RESTART;
        end
        cprhst_pkg::ST_ENC_WAIT:
          // both writes land right after a vsync fall
          if (enc_val_q && !auth_q)
            st_q <= cprhst_pkg::ST_RUN;
          else if (vs_fall_w)
          begin
            sub_q <= 1'b0;
            st_q <= cprhst_pkg::ST_ENC_WR;
          end
        cprhst_pkg::ST_ENC_WR:
          if (done_w)
          begin
            sub_q <= 1'b1;
            if (sub_q)
            begin
              enc_q <= enc_val_q;
              st_q <= enc_val_q ? cprhst_pkg::ST_RUN :
                      (go_q || fail_q) ? cprhst_pkg::ST_RESTART :
                      cprhst_pkg::ST_RUN;
            end
          end
        default:
          st_q <= cprhst_pkg::ST_IDLE;
      endcase
    end
  end

  // outputs
  assign reg_req = req_q;
  assign reg_wr = wr_q;
  assign reg_dev = dev_q;
  assign reg_addr = addr_q;
  assign reg_wdata = wd_q;
  assign busy = (st_q != cprhst_pkg::ST_IDLE) &
                (st_q != cprhst_pkg::ST_RUN);
  assign authenticated = auth_q;
  assign auth_failed = fail_q;
  assign receiver_key_invalid_flag = (ones_q != cprhst_pkg::KEY_ONES);
  assign enc_active = enc_q;
  assign content_allow = auth_q & enc_q & ~key_revoked;
  assign last_response = rx_q;

endmodule

`default_nettype wire

// ---- verif/cprhst_chk_sva.sv ----
/* checker on the sequencer top ports.
   assumes reset low at time zero. */
`timescale 1ns/1ps
`default_nettype none
module cprhst_chk
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic reg_dev,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_ack,
  // status and timing
  input wire logic vsync,
  input wire logic key_revoked,
  input wire logic authenticated,
  input wire logic auth_failed,
  input wire logic enc_active,
  input wire logic content_allow,
  input wire logic [15:0] last_response
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // completed transfer
  wire done = reg_req && reg_ack;
  // cipher-on write to the serializer
  wire enc_s = done && reg_wr && !reg_dev && reg_addr == 8'h80
    && reg_wdata[cprhst_pkg::CTL_ENC];
  // any control write to the deserializer
  wire ctl_d = done && reg_wr && reg_dev && reg_addr == 8'h80;
  // device read completed
  wire rd_d = done && !reg_wr && reg_dev;
  a_req_hold: assert property (reg_req && !reg_ack |=> reg_req
    && $stable({reg_wr, reg_dev, reg_addr, reg_wdata}))
    else $error("request changed before ack");
  a_req_gap: assert property (done |=> !reg_req)
    else $error("request not dropped after ack");
  a_allow_eq: assert property (content_allow ==
    (authenticated && enc_active && !key_revoked))
    else $error("content allow wrong");
  a_enc_auth: assert property ($rose(enc_active) |-> authenticated)
    else $error("cipher on without authentication");
  a_enc_pair: assert property (enc_s |=> !$fell(vsync) until ctl_d)
    else $error("vsync fall between cipher writes");
  a_enc_bound: assert property (enc_s |-> ##[1:40] ctl_d)
    else $error("second cipher write missing");
  a_resp_hold: assert property ($changed(last_response) |->
    $past(rd_d) || $past(rd_d, 2) || $past(rd_d, 3))
    else $error("response changed without read");
  a_pass_fail: assert property (authenticated |-> !auth_failed)
    else $error("pass and fail together");
endmodule
bind cprhst_ctrl cprhst_chk u_chk (.mclk, .arst_n, .reg_req, .reg_wr,
  .reg_dev, .reg_addr, .reg_wdata, .reg_ack, .vsync, .key_revoked,
  .authenticated, .auth_failed, .enc_active, .content_allow,
  .last_response);
`default_nettype wire

// ---- verif/cprhst_far.sv ----
/* far-end model: both link ends' register spaces.
   assumes one open request at a time. */
`timescale 1ns/1ps
`default_nettype none
module cprhst_far
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic reg_dev,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic reg_ack,
  output logic [7:0] reg_rdata,
  // bench knobs
  input wire logic [63:0] an_val,
  input wire logic [39:0] rx_key,
  input wire logic [1:0] lag,
  input wire logic bad_resp
);
  localparam logic [39:0] TXK = 40'h5a5a5a5a5a; // 20 ones
  logic [7:0] sr [256]; // serializer space
  logic [7:0] dr [256]; // deserializer space
  logic [1:0] wait_q; // ack delay so far
  logic [15:0] r_s, r_d; // both responses
  // cipher stand-in: same mix of copied bytes at both ends
  assign r_d = {dr[8'h91] ^ dr[8'h99] ^ dr[8'ha1],
    dr[8'h90] ^ dr[8'h98] ^ dr[8'ha0]};
  assign r_s = {sr[8'h91] ^ sr[8'h99] ^ sr[8'ha1],
    sr[8'h90] ^ sr[8'h98] ^ sr[8'ha0] ^ {7'h0, bad_resp}};
  // idle data toggles so a stale byte never passes
  always @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      reg_ack <= 1'b0;
      wait_q <= 2'h0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
        dr[8'ha0 + i] <= rx_key[8 * i +: 8];
      dr[8'ha8] <= r_d[7:0];
      dr[8'ha9] <= r_d[15:8];
      dr[8'hac] <= r_d[7:0];
      sr[8'ha8] <= r_s[7:0];
      sr[8'ha9] <= r_s[15:8];
      sr[8'hac] <= r_s[7:0];
      sr[8'had] <= {7'h0, {sr[8'hab], sr[8'haa]} == r_s};
      reg_ack <= 1'b0;
      reg_rdata <= ~reg_rdata;
      wait_q <= 2'h0;
      if (reg_req && !reg_ack && wait_q != lag)
        wait_q <= wait_q + 2'h1;
      else if (reg_req && !reg_ack)
      begin
        reg_ack <= 1'b1;
        reg_rdata <= reg_dev ? dr[reg_addr] : sr[reg_addr];
        if (reg_wr && reg_dev)
          dr[reg_addr] <= reg_wdata;
        if (reg_wr && !reg_dev)
          sr[reg_addr] <= reg_wdata;
        // start order loads a fresh random value and key
        if (reg_wr && !reg_dev && reg_addr == 8'h80 && reg_wdata[0])
        begin
          for (int i = 0; i < 8; i++)
            sr[8'h90 + i] <= an_val[8 * i +: 8];
          for (int i = 0; i < 5; i++)
            sr[8'h98 + i] <= TXK[8 * i +: 8];
        end
      end
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
/* bench: sequencer against the far-end model.
   assumes vsync made here, synchronous to mclk. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [39:0] KOK = 40'h33cc33cc33; // 20 ones
  // user side
  logic mclk = 1'b0, arst_n = 1'b0, start_auth = 1'b0, vsync = 1'b0;
  logic int_comp_sel = 1'b0, repeater_sel = 1'b0, key_revoked = 1'b0;
  logic enc_request = 1'b0, enh_check_en = 1'b0, bad_resp = 1'b0;
  logic [4:0] rx_total = 5'h01;
  logic [63:0] an_val = 64'h0;
  logic [39:0] rx_key = KOK;
  logic [1:0] lag = 2'h0;
  logic busy, authenticated, auth_failed, receiver_key_invalid_flag;
  logic enc_active, content_allow, reg_req, reg_wr, reg_dev, reg_ack;
  logic [15:0] last_response;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  // bench state
  int error_cnt = 0, n_checks = 0, op_k = 0, vcnt = 0;
  logic [7:0] last_rd = 8'h00; // byte last read
  logic [17:0] last_op = 18'h0; // last transfer
  logic [25:0] e; // mask and expected transfer
  cprhst_ctrl #(.CHK_PERIOD_CYC(4000)) DUT (.mclk, .arst_n, .start_auth,
    .int_comp_sel, .repeater_sel, .key_revoked, .rx_total, .enc_request,
    .enh_check_en, .busy, .authenticated, .auth_failed,
    .receiver_key_invalid_flag, .enc_active, .content_allow,
    .last_response, .reg_req, .reg_wr, .reg_dev, .reg_addr, .reg_wdata,
    .reg_ack, .reg_rdata, .vsync);
  cprhst_far far (.mclk, .arst_n, .reg_req, .reg_wr, .reg_dev, .reg_addr,
    .reg_wdata, .reg_ack, .reg_rdata, .an_val, .rx_key, .lag, .bad_resp);
  always #25 mclk = ~mclk;
  // frames of 200 clocks
  always @(negedge mclk)
  begin
    vcnt <= vcnt + 1;
    vsync <= (vcnt % 200) < 20;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // session opening and key copy, as mask then expected value
  function automatic logic [25:0] exp_op(int k);
    int j;
    logic s;
    logic [7:0] a;
    j = (k - 3) / 2;
    s = j >= 13;
    a = 8'(j < 13 ? 8'h90 + j : 8'h93 + j);
    if (k == 0)
      return {8'h02, 10'h280, 8'h02};
    if (k == 1)
      return {8'hff, 10'h280, 4'h0, int_comp_sel, 3'h1};
    if (k == 2)
      return {8'h14, 10'h380, 3'h0, repeater_sel, 4'h0};
    if ((k - 3) % 2 == 0)
      return {8'h00, 1'b0, s, a, 8'h00};
    return {8'hff, 1'b1, !s, a, last_rd};
  endfunction
  // every completed transfer, looked at off the sampling edge
  always @(negedge mclk)
    if (reg_req && reg_ack)
    begin
      e = exp_op(op_k);
      if (op_k < 39)
        chk("op", {reg_wr, reg_dev, reg_addr, reg_wdata & e[25:18]},
          e[17:0]);
      if (!reg_wr)
        last_rd = reg_rdata;
      last_op = {reg_wr, reg_dev, reg_addr, reg_wdata};
      op_k++;
    end
  task automatic run(logic ic, rp, bd, logic [39:0] ky, logic [4:0] rt,
    logic rv, ok);
    logic [15:0] r;
    @(negedge mclk);
    {int_comp_sel, repeater_sel, bad_resp, key_revoked} = {ic, rp, bd, rv};
    rx_key = ky;
    rx_total = rt;
    an_val = {$urandom, $urandom};
    lag = 2'($urandom);
    op_k = 0;
    start_auth = 1'b1;
    @(negedge mclk);
    start_auth = 1'b0;
    for (int n = 0; n < 4000 && busy !== 1'b0; n++)
      @(negedge mclk);
    r = an_val[15:0] ^ far.TXK[15:0] ^ ky[15:0];
    chk("auth", {busy, authenticated, auth_failed},
      {1'b0, ok, !ok});
    chk("kinv", receiver_key_invalid_flag, $countones(ky) != 20);
    if (ok)
      chk("resp", last_response, r);
    if (bd)
      chk("again", {last_op[17:8], last_op[1]}, {10'h280, 1'b1});
  endtask
  task automatic wait_enc(logic v);
    for (int n = 0; n < 2000 && enc_active !== v; n++)
      @(negedge mclk);
    chk("enc", enc_active, v);
  endtask
  initial
  begin
    void'($urandom(32'hc2ae62a1));
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    chk("rstv", {busy, authenticated, receiver_key_invalid_flag}, 3'h1);
    run(0, 0, 0, KOK, 5'd15, 0, 1);
    run(1, 1, 0, KOK, 5'd3, 0, 1);
    enc_request = 1'b1;
    enh_check_en = 1'b1;
    wait_enc(1'b1);
    chk("allow", content_allow, 1'b1);
    key_revoked = 1'b1;
    @(negedge mclk);
    chk("deny", content_allow, 1'b0);
    key_revoked = 1'b0;
    repeat (4600) @(negedge mclk);
    chk("keep", {authenticated, enc_active}, 2'h3);
    enc_request = 1'b0;
    wait_enc(1'b0);
    run(0, 0, 1, KOK, 5'd1, 0, 0);
    run(1, 0, 1, KOK, 5'd1, 0, 0);
    run(0, 0, 0, 40'h33cc33cc32, 5'd1, 0, 0);
    run(0, 0, 0, KOK, 5'd16, 0, 0);
    run(0, 0, 0, KOK, 5'd1, 1, 0);
    enc_request = 1'b1;
    repeat (600) @(negedge mclk);
    chk("noenc", enc_active, 1'b0);
    print_verdict;
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
